// ===== design/touch_sense_pkg.sv
// Constants, register map and state record of the touch sensing controller.
// Assumes a single 100 MHz bus clock; registers reached over AXI4-Lite.
// Summary of operation
// [RULE1] Each group has four pins; one sample pin, any number of channel pins.
// [RULE2] Software never selects one pin as both sample and channel.
// [RULE3] Controller drives input, high or low; the running sequence sets the mode.
// [RULE4] When idle, the idle pin-mode bit sets channel, sample and free pins.
// [RULE5] While running, channel and sample switches follow the sequence step.
// [RULE6] While idle, every switch follows its bit in the switch control register.
// [RULE7] While idle, switches stay controlled even for pins not handed over.
// [RULE8] Software may run its own sequence through switch bits and GPIO modes.
// [RULE9] While enabled, controller pin setup overrides GPIO and other peripherals.
// [RULE10] A cleared hysteresis bit turns that pin's Schmitt hysteresis off.
// [RULE11] Software configures all registers first, then sets the enable bit.
// [RULE12] The module enable bit turns the controller on.
// [RULE13] Trigger-mode 0 starts on start bit; 1 starts on trigger pin edge.
// [RULE14] All enabled groups at threshold stops and sets completion flag; W1C.
// [RULE15] Cycle count at maximum stops and sets max-cycle error flag; W1C.
// [RULE16] After a stop flag, software reads each group's cycle count.
// [RULE17] Charge state lasts field+1 transfer-clock periods, 1 to 16.
// [RULE18] Transfer state lasts field+1 transfer-clock periods, 1 to 16.
// [RULE19] Extend charge maximum is field+1 extend-clock periods, 1 to 128.
// [RULE20] Idle pin-mode 0 drives pins low when idle; 1 leaves them floating.
// [RULE21] Hardware clears start bit at stop; software clearing it aborts.
// [RULE22] Max cycle field selects 255 up to 16383; encoding 111 reserved.
// [RULE23] Edge select 0 means falling edge, 1 means rising edge.
// [RULE24] Interrupt request when a stop flag and its enable bit are both set.
package touch_sense_pkg;

  localparam int NUM_GROUPS = 6;
  localparam int NUM_PINS = NUM_GROUPS * 4;
  localparam int CNT_W = 14;

  // --------
  // Register byte offsets
  // --------
  localparam logic [7:0] OFS_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CTL1 = 8'h04;
  localparam logic [7:0] OFS_INTEN = 8'h08;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h0C;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_SWITCH = 8'h14;
  localparam logic [7:0] OFS_HYST = 8'h18;
  localparam logic [7:0] OFS_CHAN = 8'h1C;
  localparam logic [7:0] OFS_SAMP = 8'h20;
  localparam logic [7:0] OFS_GROUP_EN = 8'h24;
  localparam logic [7:0] OFS_GCNT0 = 8'h30;

  // --------
  // Field positions and reset values
  // --------
  localparam int B_CHARGE_LSB = 28;
  localparam int B_XFER_LSB = 24;
  localparam int B_EXTMAX_LSB = 17;
  localparam int B_EXT_EN = 16;
  localparam int B_EXTDIV0 = 15;
  localparam int B_XDIV_LSB = 12;
  localparam int B_MAXCYC_LSB = 5;
  localparam int B_IDLE_PINMODE = 4;
  localparam int B_EDGE_SEL = 3;
  localparam int B_TRIG_MODE = 2;
  localparam int B_START = 1;
  localparam int B_ENABLE = 0;
  localparam int B_CTL1_XDIV3 = 24;
  localparam int B_CTL1_EXTDIV_LSB = 25;
  localparam int B_DONE = 0;
  localparam int B_MAXERR = 1;
  localparam logic [31:0] CTL0_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL0_WMASK = 32'hFFFF_F0FF;
  localparam logic [31:0] CTL1_WMASK = 32'h0F00_0000;
  localparam logic [31:0] HYST_RESET = 32'h00FF_FFFF;
  localparam logic [1:0] BUF_CYCLES = 2'h2;
  localparam logic [15:0] MAXCYC_BASE = 16'h0100;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BUF1, ST_CHARGE, ST_EXTEND, ST_BUF2, ST_XFER, ST_BUF3, ST_COMPARE
  } seq_state_t;

  // Whole state of the controller as one record
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [1:0] r_resp;
    logic [31:0] r_data;
    logic [31:0] ctl0;
    logic [31:0] ctl1;
    logic [1:0] inten;
    logic [1:0] flags;
    logic [NUM_PINS-1:0] sw_bits;
    logic [NUM_PINS-1:0] hyst;
    logic [NUM_PINS-1:0] chan;
    logic [NUM_PINS-1:0] samp;
    logic [NUM_GROUPS-1:0] grp_en;
    seq_state_t st;
    logic [7:0] tmr;
    logic [14:0] xdiv_cnt;
    logic [2:0] ediv_cnt;
    logic [7:0] ext_len;
    logic ext_up;
    logic [CNT_W-1:0] cycles;
    logic [NUM_GROUPS-1:0] reached;
    logic [NUM_GROUPS-1:0][CNT_W-1:0] gcnt;
    logic trig_q;
  } ctrl_state_t;

endpackage

// ===== design/touch_sense_pin_switch_ctrl.sv
// Touch sensing controller: register file, charge-transfer sequencer and pad control.
// Assumes pad inputs and comparator results are synchronous to CLOCK.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module touch_sense_pin_switch_ctrl
  import touch_sense_pkg::*;
(
  input wire logic CLOCK, // Bus and sequencer clock
  input wire logic RST, // Asynchronous reset, high
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [7:0] S_AXI_AWADDR, // Write byte address
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Byte enables
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  output logic [1:0] S_AXI_BRESP, // Write response
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  input wire logic [7:0] S_AXI_ARADDR, // Read byte address
  output logic S_AXI_RVALID, // Read data valid
  input wire logic S_AXI_RREADY, // Read data ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  input wire logic [NUM_PINS-1:0] PIN_ASSIGNED, // GPIO hands pin to controller
  input wire logic [NUM_GROUPS-1:0] SAMPLE_AT_THRESHOLD, // Sample comparator per group
  input wire logic TRIGGER_IN, // External trigger pin level
  output logic [NUM_PINS-1:0] PIN_OVERRIDE, // Controller owns the pad
  output logic [NUM_PINS-1:0] PIN_OUT, // Pad output level
  output logic [NUM_PINS-1:0] PIN_OE_N, // Pad output enable, low drives
  output logic [NUM_PINS-1:0] SWITCH_CLOSE, // Analog switch closed
  output logic [NUM_PINS-1:0] HYST_ENABLE, // Schmitt hysteresis on
  output logic IRQ // Interrupt request
);

  ctrl_state_t s_reg;
  ctrl_state_t s_next;
  logic enabled;
  logic running;
  logic [NUM_PINS-1:0] samp_eff;
  logic [NUM_PINS-1:0] chan_eff;
  logic [NUM_PINS-1:0] used;

  // --------
  // Helpers
  // --------
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be, input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    return (old & ~m) | (d & m);
  endfunction

  // Lowest set bit of a group's four-bit sample field
  function automatic logic [3:0] first_bit(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction

  // --------
  // Pin roles
  // --------
  // One sample pin per group; a sample pin is never also a channel
  always_comb
  begin
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      samp_eff[g*4 +: 4] = first_bit(s_reg.samp[g*4 +: 4]); // RULE1
    end
    chan_eff = s_reg.chan & ~samp_eff; // RULE1
    used = chan_eff | samp_eff;
  end

  assign enabled = s_reg.ctl0[B_ENABLE]; // RULE12
  assign running = (s_reg.st != ST_IDLE);

  // --------
  // Next-state logic
  // --------
  always_comb
  begin
    logic [3:0] xsel;
    logic [2:0] esel;
    logic [14:0] xlim;
    logic xtick;
    logic etick;
    logic trig_edge;
    logic [CNT_W-1:0] maxc;
    logic [NUM_GROUPS-1:0] now_reached;
    logic [1:0] hw_set;
    logic [7:0] ext_max;
    logic [3:0] charge_len;
    logic [3:0] xfer_len;
    logic wr_fire;
    s_next = s_reg;
    hw_set = 2'b00;
    xsel = {s_reg.ctl1[B_CTL1_XDIV3], s_reg.ctl0[B_XDIV_LSB +: 3]};
    esel = {s_reg.ctl1[B_CTL1_EXTDIV_LSB +: 2], s_reg.ctl0[B_EXTDIV0]};
    charge_len = s_reg.ctl0[B_CHARGE_LSB +: 4];
    xfer_len = s_reg.ctl0[B_XFER_LSB +: 4];
    ext_max = {1'b0, s_reg.ctl0[B_EXTMAX_LSB +: 7]} + 8'h01; // RULE19
    // Transfer clock divides by 2^sel, extend clock by sel+1
    xlim = 15'((16'h0001 << xsel) - 16'h0001);
    xtick = (s_reg.xdiv_cnt >= xlim);
    etick = (s_reg.ediv_cnt >= esel);
    s_next.xdiv_cnt = xtick ? 15'h0000 : s_reg.xdiv_cnt + 15'h0001;
    s_next.ediv_cnt = etick ? 3'h0 : s_reg.ediv_cnt + 3'h1;
    // Cycle limit per max cycle field; reserved code takes the largest
    if (s_reg.ctl0[B_MAXCYC_LSB +: 3] == 3'h7)
    begin
      maxc = '1; // RULE22
    end
    else
    begin
      maxc = CNT_W'((MAXCYC_BASE << s_reg.ctl0[B_MAXCYC_LSB +: 3]) - 16'h0001); // RULE22
    end
    // Trigger edge per edge select bit
    s_next.trig_q = TRIGGER_IN;
    trig_edge = s_reg.ctl0[B_EDGE_SEL] ? (TRIGGER_IN & ~s_reg.trig_q)
                                       : (~TRIGGER_IN & s_reg.trig_q); // RULE23
    now_reached = s_reg.reached | (SAMPLE_AT_THRESHOLD & s_reg.grp_en);

    // Sequencer
    unique case (s_reg.st)
      ST_IDLE:
      begin
        if (enabled && (s_reg.ctl0[B_TRIG_MODE] ? trig_edge : s_reg.ctl0[B_START])) // RULE13
        begin
          s_next.ctl0[B_START] = 1'b1;
          s_next.st = ST_BUF1;
          s_next.tmr = 8'h00;
          s_next.cycles = '0;
          s_next.reached = '0;
          s_next.gcnt = '0;
          s_next.ext_len = 8'h00;
          s_next.ext_up = 1'b1;
        end
      end
      ST_BUF1, ST_BUF2, ST_BUF3:
      begin
        s_next.tmr = s_reg.tmr + 8'h01;
        if (s_reg.tmr == 8'(BUF_CYCLES - 2'h1))
        begin
          s_next.tmr = 8'h00;
          unique case (s_reg.st)
            ST_BUF1: s_next.st = ST_CHARGE;
            ST_BUF2: s_next.st = ST_XFER;
            default: s_next.st = ST_COMPARE;
          endcase
        end
      end
      ST_CHARGE, ST_XFER:
      begin
        if (xtick)
        begin
          s_next.tmr = s_reg.tmr + 8'h01;
          if (s_reg.tmr[3:0] == ((s_reg.st == ST_CHARGE) ? charge_len : xfer_len)) // RULE17 RULE18
          begin
            s_next.tmr = 8'h00;
            if (s_reg.st == ST_XFER)
            begin
              s_next.st = ST_BUF3;
            end
            else if (s_reg.ctl0[B_EXT_EN] && s_reg.ext_len != 8'h00)
            begin
              s_next.st = ST_EXTEND;
            end
            else
            begin
              s_next.st = ST_BUF2;
            end
          end
        end
      end
      ST_EXTEND:
      begin
        if (etick)
        begin
          s_next.tmr = s_reg.tmr + 8'h01;
          if (s_next.tmr == s_reg.ext_len)
          begin
            s_next.tmr = 8'h00;
            s_next.st = ST_BUF2;
          end
        end
      end
      ST_COMPARE:
      begin
        // Count a cycle for every enabled group still below threshold
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
          if (s_reg.grp_en[g] && !s_reg.reached[g])
          begin
            s_next.gcnt[g] = s_reg.gcnt[g] + CNT_W'(1);
          end
        end
        s_next.reached = now_reached;
        s_next.cycles = s_reg.cycles + CNT_W'(1);
        // Extend length walks a triangle between 0 and its maximum
        if (s_reg.ext_up && s_reg.ext_len >= ext_max)
        begin
          s_next.ext_up = 1'b0;
          s_next.ext_len = s_reg.ext_len - 8'h01;
        end
        else if (!s_reg.ext_up && s_reg.ext_len == 8'h00)
        begin
          s_next.ext_up = 1'b1;
          s_next.ext_len = 8'h01;
        end
        else
        begin
          s_next.ext_len = s_reg.ext_up ? s_reg.ext_len + 8'h01 : s_reg.ext_len - 8'h01;
        end
        s_next.st = ST_BUF1;
        if (now_reached == s_reg.grp_en)
        begin
          hw_set[B_DONE] = 1'b1; // RULE14
        end
        else if (s_next.cycles == maxc)
        begin
          hw_set[B_MAXERR] = 1'b1; // RULE15
        end
        if (hw_set != 2'b00)
        begin
          s_next.st = ST_IDLE;
          s_next.ctl0[B_START] = 1'b0; // RULE21
        end
      end
    endcase

    // Software abort by clearing start, or disable, ends the run without a flag
    if (running && (!s_reg.ctl0[B_START] || !enabled))
    begin
      s_next.st = ST_IDLE; // RULE21
      s_next.tmr = 8'h00;
    end

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && !s_reg.aw_have)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_reg.w_have)
    begin
      s_next.w_have = 1'b1;
      s_next.w_data = S_AXI_WDATA;
      s_next.w_strb = S_AXI_WSTRB;
    end
    if (s_reg.b_valid && S_AXI_BREADY)
    begin
      s_next.b_valid = 1'b0;
    end
    wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.b_valid;
    if (wr_fire)
    begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.b_valid = 1'b1;
      s_next.b_resp = RESP_OKAY;
      unique case (s_reg.aw_addr)
        OFS_CTL0: s_next.ctl0 = merge(s_next.ctl0, s_reg.w_data, s_reg.w_strb, CTL0_WMASK);
        OFS_CTL1: s_next.ctl1 = merge(s_reg.ctl1, s_reg.w_data, s_reg.w_strb, CTL1_WMASK);
        OFS_INTEN: s_next.inten = 2'(merge({30'h0, s_reg.inten}, s_reg.w_data, s_reg.w_strb,
                                           32'h0000_0003));
        OFS_FLAG_CLR: s_next.flags = s_reg.flags & ~(s_reg.w_data[1:0] & {2{s_reg.w_strb[0]}}); // RULE14 RULE15
        OFS_SWITCH: s_next.sw_bits = NUM_PINS'(merge(32'(s_reg.sw_bits), s_reg.w_data,
                                                     s_reg.w_strb, 32'h00FF_FFFF));
        OFS_HYST: s_next.hyst = NUM_PINS'(merge(32'(s_reg.hyst), s_reg.w_data, s_reg.w_strb,
                                                32'h00FF_FFFF));
        OFS_CHAN: s_next.chan = NUM_PINS'(merge(32'(s_reg.chan), s_reg.w_data, s_reg.w_strb,
                                                32'h00FF_FFFF));
        OFS_SAMP: s_next.samp = NUM_PINS'(merge(32'(s_reg.samp), s_reg.w_data, s_reg.w_strb,
                                                32'h00FF_FFFF));
        OFS_GROUP_EN: s_next.grp_en = NUM_GROUPS'(merge(32'(s_reg.grp_en), s_reg.w_data,
                                                        s_reg.w_strb, 32'h0000_003F));
        OFS_FLAG: s_next.b_resp = RESP_OKAY;
        default:
        begin
          if (!(s_reg.aw_addr >= OFS_GCNT0 && s_reg.aw_addr < OFS_GCNT0 + 8'(4 * NUM_GROUPS)))
          begin
            s_next.b_resp = RESP_SLVERR;
          end
        end
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    s_next.flags = s_next.flags | hw_set; // RULE14 RULE15

    // Read channel: one read in flight, data registered
    if (s_reg.r_valid && S_AXI_RREADY)
    begin
      s_next.r_valid = 1'b0;
    end
    if (S_AXI_ARVALID && !s_reg.r_valid)
    begin
      s_next.r_valid = 1'b1;
      s_next.r_resp = RESP_OKAY;
      s_next.r_data = 32'h0000_0000;
      unique case (S_AXI_ARADDR)
        OFS_CTL0: s_next.r_data = s_reg.ctl0;
        OFS_CTL1: s_next.r_data = s_reg.ctl1;
        OFS_INTEN: s_next.r_data = {30'h0, s_reg.inten};
        OFS_FLAG_CLR: s_next.r_data = 32'h0000_0000;
        OFS_FLAG: s_next.r_data = {30'h0, s_reg.flags};
        OFS_SWITCH: s_next.r_data = 32'(s_reg.sw_bits);
        OFS_HYST: s_next.r_data = 32'(s_reg.hyst);
        OFS_CHAN: s_next.r_data = 32'(s_reg.chan);
        OFS_SAMP: s_next.r_data = 32'(s_reg.samp);
        OFS_GROUP_EN: s_next.r_data = 32'(s_reg.grp_en);
        default:
        begin
          s_next.r_resp = RESP_SLVERR;
          for (int g = 0; g < NUM_GROUPS; g++)
          begin
            if (S_AXI_ARADDR == OFS_GCNT0 + 8'(4 * g))
            begin
              s_next.r_data = 32'(s_reg.gcnt[g]); // RULE16
              s_next.r_resp = RESP_OKAY;
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      s_reg <= '0;
      s_reg.ctl0 <= CTL0_RESET;
      s_reg.hyst <= HYST_RESET[NUM_PINS-1:0];
      s_reg.st <= ST_IDLE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // --------
  // Pads, switches and bus outputs
  // --------
  // Charge and extend drive channel pins high; other steps float them
  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      PIN_OVERRIDE[p] = enabled && PIN_ASSIGNED[p]; // RULE9
      PIN_OUT[p] = 1'b0;
      PIN_OE_N[p] = 1'b1;
      if (running && used[p])
      begin
        if (chan_eff[p] && (s_reg.st == ST_CHARGE || s_reg.st == ST_EXTEND))
        begin
          PIN_OUT[p] = 1'b1; // RULE3
          PIN_OE_N[p] = 1'b0; // RULE3
        end
      end
      else
      begin
        PIN_OE_N[p] = s_reg.ctl0[B_IDLE_PINMODE]; // RULE4 RULE20
      end
      if (running && used[p])
      begin
        SWITCH_CLOSE[p] = (s_reg.st == ST_XFER); // RULE5
      end
      else
      begin
        SWITCH_CLOSE[p] = s_reg.sw_bits[p]; // RULE6 RULE7
      end
      HYST_ENABLE[p] = s_reg.hyst[p]; // RULE10
    end
  end

  assign IRQ = |(s_reg.flags & s_reg.inten); // RULE24
  assign S_AXI_AWREADY = !s_reg.aw_have;
  assign S_AXI_WREADY = !s_reg.w_have;
  assign S_AXI_BVALID = s_reg.b_valid;
  assign S_AXI_BRESP = s_reg.b_resp;
  assign S_AXI_ARREADY = !s_reg.r_valid;
  assign S_AXI_RVALID = s_reg.r_valid;
  assign S_AXI_RDATA = s_reg.r_data;
  assign S_AXI_RRESP = s_reg.r_resp;

endmodule // touch_sense_pin_switch_ctrl
`default_nettype wire

// ===== tb/touch_sense_chk.sv
// Port-level assertions for the touch sensing controller.
// Assumes it is bound onto the top module and shares its single clock.
`timescale 1ns/1ps
`default_nettype none
module touch_sense_chk
  import touch_sense_pkg::*;
(
  input wire logic CLOCK, // Clock
  input wire logic RST, // Reset, high
  input wire logic S_AXI_AWVALID, // Write address valid
  input wire logic S_AXI_AWREADY, // Write address ready
  input wire logic S_AXI_WVALID, // Write data valid
  input wire logic S_AXI_WREADY, // Write data ready
  input wire logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  input wire logic [1:0] S_AXI_BRESP, // Write response
  input wire logic S_AXI_ARVALID, // Read address valid
  input wire logic S_AXI_ARREADY, // Read address ready
  input wire logic S_AXI_RVALID, // Read data valid
  input wire logic [NUM_PINS-1:0] PIN_ASSIGNED, // Pins handed over
  input wire logic [NUM_PINS-1:0] PIN_OVERRIDE, // Controller owns pad
  input wire logic [NUM_PINS-1:0] PIN_OUT, // Pad level
  input wire logic [NUM_PINS-1:0] PIN_OE_N, // Pad drive, low drives
  input wire logic [NUM_PINS-1:0] SWITCH_CLOSE, // Analog switches
  input wire logic [NUM_PINS-1:0] HYST_ENABLE // Hysteresis
);
  // --------
  // Properties
  // --------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_wr_lat;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response not two cycles on");
  property p_rd_lat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> $rose(S_AXI_RVALID);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data not one cycle on");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_ar_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
  // A pad driven high is charging; its switch must stay open then
  property p_charge_open;
    (PIN_OUT & ~PIN_OE_N & SWITCH_CLOSE) == '0;
  endproperty
  a_charge_open: assert property (p_charge_open) else $error("switch closed on driven pin");
  property p_own_sub;
    (PIN_OVERRIDE & ~PIN_ASSIGNED) == '0;
  endproperty
  a_own_sub: assert property (p_own_sub) else $error("pad owned without handover");
  property p_own_wr;
    $changed(PIN_OVERRIDE) && $stable(PIN_ASSIGNED) |-> S_AXI_BVALID;
  endproperty
  a_own_wr: assert property (p_own_wr) else $error("ownership moved without write");
  property p_hyst_wr;
    $changed(HYST_ENABLE) |-> S_AXI_BVALID || $past(S_AXI_BVALID);
  endproperty
  a_hyst_wr: assert property (p_hyst_wr) else $error("hysteresis moved without write");
endmodule // touch_sense_chk
bind touch_sense_pin_switch_ctrl touch_sense_chk u_chk (.CLOCK(CLOCK), .RST(RST),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .PIN_ASSIGNED(PIN_ASSIGNED), .PIN_OVERRIDE(PIN_OVERRIDE),
  .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .SWITCH_CLOSE(SWITCH_CLOSE), .HYST_ENABLE(HYST_ENABLE));
`default_nettype wire

// ===== tb/electrode_model.sv
// Electrode and sampling capacitor of group 0, sample pad at pin 1.
// Assumes pads and switches are sampled on the controller clock.
`timescale 1ns/1ps
`default_nettype none
module electrode_model
  import touch_sense_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic [NUM_PINS-1:0] sw, // Analog switches
  input wire logic [NUM_PINS-1:0] pin_out, // Pad level
  input wire logic [NUM_PINS-1:0] oe_n, // Pad drive
  input wire logic [15:0] reach_after, // Transfers to threshold
  output logic [NUM_GROUPS-1:0] at_thr // Comparator per group
);
  logic [15:0] charge_reg;
  logic sw_q;
  // Each closed transfer adds charge; a sample pad driven low empties it
  always_ff @(posedge clk)
  begin
    sw_q <= sw[1];
    if (!oe_n[1] && !pin_out[1])
      charge_reg <= 16'h0000;
    else if (sw[1] && !sw_q)
      charge_reg <= charge_reg + 16'h0001;
  end
  assign at_thr = {NUM_GROUPS{charge_reg >= reach_after}};
endmodule // electrode_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench: register access over AXI4-Lite, sequences with an electrode model.
// Assumes the controller, its package and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import touch_sense_pkg::*;
  logic clk, rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, trig, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, rdata;
  logic [1:0] bresp, rresp, rsp;
  logic [NUM_PINS-1:0] assigned, own, pin_out, oe_n, sw, hyst;
  logic [NUM_GROUPS-1:0] at_thr;
  logic [15:0] reach;
  int check_count, n_mismatch, run_c, run_x, chg_len, xfr_len;
  touch_sense_pin_switch_ctrl DUT (.CLOCK(clk), .RST(rst), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .PIN_ASSIGNED(assigned), .SAMPLE_AT_THRESHOLD(at_thr), .TRIGGER_IN(trig),
    .PIN_OVERRIDE(own), .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .SWITCH_CLOSE(sw),
    .HYST_ENABLE(hyst), .IRQ(irq));
  electrode_model u_elec (.clk(clk), .sw(sw), .pin_out(pin_out), .oe_n(oe_n),
    .reach_after(reach), .at_thr(at_thr));
  // --------
  // Clock and pulse-length monitor on pin 0
  // --------
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    run_c = (pin_out[0] && !oe_n[0]) ? run_c + 1 : 0;
    run_x = sw[0] ? run_x + 1 : 0;
    if (run_c != 0)
      chg_len = run_c;
    if (run_x != 0)
      xfr_len = run_x;
  end
  // --------
  // Tasks
  // --------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 200)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // Write one word; response ready raised only once the response shows
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    awv <= 1'h1;
    awa <= a;
    wv <= 1'h1;
    wd <= d;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'h0;
      if (wr)
        wv <= 1'h0;
      if (bv)
        br <= 1'h1;
      n++;
    end while (!(bv === 1'h1 && br === 1'h1) && n < 200);
    br <= 1'h0;
    hang(n);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n = 0;
    @(posedge clk);
    arv <= 1'h1;
    ara <= a;
    rr <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'h0;
      n++;
    end while (rv !== 1'h1 && n < 200);
    rd = rdata;
    rsp = rresp;
    rr <= 1'h0;
    hang(n);
  endtask
  // Poll the flag register until a stop flag shows
  task automatic wait_flag();
    int n = 0;
    do
    begin
      rd_reg(OFS_FLAG);
      n++;
    end while (rd[1:0] == 2'h0 && n < 2000);
    hang(n / 10);
  endtask
  // --------
  // Main sequence
  // --------
  initial
  begin
    {awv, wv, br, arv, rr, trig, awa, ara, wd} = '0;
    assigned = 24'hFF_FFFF;
    reach = 16'h0003;
    rst = 1'h1;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    chk({hyst, oe_n[7:0]}, 32'hFFFF_FF00);
    chk({8'h00, own}, 32'h0000_0000);
    rd_reg(OFS_CTL0);
    chk(rd, CTL0_RESET);
    rd_reg(8'h2C);
    chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    $display("test reset done");
    assigned <= 24'h00_0000;
    wr_reg(OFS_SWITCH, 32'h005A_C3A5);
    chk({8'h00, sw}, 32'h005A_C3A5);
    wr_reg(OFS_SWITCH, 32'h0000_0000);
    wr_reg(OFS_HYST, 32'h00FF_FFFE);
    @(posedge clk);
    chk({8'h00, hyst}, 32'h00FF_FFFE);
    $display("test switches done");
    // Channel pin 0, sample pin 1 of group 0, configured before enable
    wr_reg(OFS_CHAN, 32'h0000_0001);
    wr_reg(OFS_SAMP, 32'h0000_0002);
    wr_reg(OFS_GROUP_EN, 32'h0000_0001);
    wr_reg(OFS_INTEN, 32'h0000_0003);
    wr_reg(OFS_CTL0, 32'h3500_0001);
    wr_reg(OFS_CTL0, 32'h3500_0003);
    wait_flag();
    chk(rd, 32'h0000_0001);
    chk({chg_len[15:0], xfr_len[15:0]}, 32'h0004_0006);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_reg(OFS_GCNT0);
    chk(rd, 32'h0000_0003);
    rd_reg(OFS_CTL0);
    chk(rd, 32'h3500_0001);
    wr_reg(OFS_FLAG_CLR, 32'h0000_0001);
    rd_reg(OFS_FLAG);
    chk({rd[30:0], irq}, 32'h0000_0000);
    $display("test completion done");
    reach <= 16'hFFFF;
    wr_reg(OFS_CTL0, 32'h3500_0003);
    wait_flag();
    chk(rd, 32'h0000_0002);
    rd_reg(OFS_GCNT0);
    chk(rd, 32'h0000_00FF);
    wr_reg(OFS_FLAG_CLR, 32'h0000_0002);
    rd_reg(OFS_FLAG);
    chk(rd, 32'h0000_0000);
    wr_reg(OFS_CTL0, 32'h3500_0003);
    wr_reg(OFS_CTL0, 32'h3500_0001);
    rd_reg(OFS_FLAG);
    chk({rd[29:0], oe_n[1], irq}, 32'h0000_0000);
    $display("test max cycle done");
    reach <= 16'h0002;
    for (int e = 0; e < 2; e++)
    begin
      trig <= e[0];
      wr_reg(OFS_CTL0, 32'h3500_0005 | (e << 3));
      trig <= !e[0];
      repeat (4) @(posedge clk);
      rd_reg(OFS_CTL0);
      chk(rd[1:0], 32'h0000_0001);
      trig <= e[0];
      wait_flag();
      chk(rd, 32'h0000_0001);
      wr_reg(OFS_FLAG_CLR, 32'h0000_0003);
    end
    $display("test trigger done");
    assigned <= 24'h00_0F0F;
    wr_reg(OFS_CTL0, 32'h0000_0011);
    chk({own, 8'h00}, 32'h000F_0F00);
    chk({8'h00, oe_n}, 32'h00FF_FFFF);
    wr_reg(OFS_CTL0, 32'h0000_0000);
    chk({8'h00, own}, 32'h0000_0000);
    $display("test ownership done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
